//--- logic/bfc_host.sv
// Purpose: host side controller driving a block erasable flash by pins
// Assumes: software port with one-cycle read latency; no wait states
// Notes: sequences commands, polls status, reports outcome in REG_STATUS
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - erase: write 20h, then D0h
// - program: setup 40h, then address/data
// - write FFh after program or erase; the code sends it only before the next read op
// - only status reads while busy
// - power-down by driving reset low
// - hold unlock until boot operation done
module bfc_host #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [31:0] sw_rdata,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_reset_powerdown_n,
   output logic flash_write_protect,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [DATA_W-1:0] flash_dq_in
);

   typedef struct packed {
      bfc_pkg::bfc_state_t st;
      bfc_pkg::bfc_pins_t pins;
      logic [2:0] op;
      logic second;
      logic unlock;
      logic busy;
      logic [7:0] last_status;
      logic need_read_array;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic [4:0] cnt;
      logic [31:0] sw_rdata;
   } bfc_host_t;

   bfc_host_t s_r;
   bfc_host_t s_nxt;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [DATA_W-1:0] cmd(input logic [7:0] c);
      cmd = DATA_W'(c);
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.sw_rdata = 32'h0000_0000;
      // software register port
      if (sw_write) begin
         case (sw_addr)
            bfc_pkg::REG_ADDR: s_nxt.addr = sw_wdata[ADDR_W-1:0];
            bfc_pkg::REG_WDATA: s_nxt.wdata = sw_wdata[DATA_W-1:0];
            bfc_pkg::REG_CTRL: begin
               // orders only taken while idle or powered down
               // a pending op is never overwritten by a new order
               if (s_r.st == bfc_pkg::S_IDLE && !s_r.busy &&
                   s_r.op == 3'h0) begin
                  s_nxt.op = sw_wdata[2:0];
                  s_nxt.unlock = sw_wdata[bfc_pkg::CTRL_BOOT_UNLOCK];
               end else if (s_r.st == bfc_pkg::S_PD &&
                            sw_wdata[2:0] == bfc_pkg::OP_WAKE) begin
                  s_nxt.op = bfc_pkg::OP_WAKE;
               end
            end
            default: ;
         endcase
      end
      if (sw_read) begin
         case (sw_addr)
            bfc_pkg::REG_ADDR: s_nxt.sw_rdata = 32'(s_r.addr);
            bfc_pkg::REG_WDATA: s_nxt.sw_rdata = 32'(s_r.wdata);
            bfc_pkg::REG_STATUS: s_nxt.sw_rdata =
               {22'h00_0000, s_r.st == bfc_pkg::S_PD, s_r.busy,
                s_r.last_status};
            bfc_pkg::REG_RDATA: s_nxt.sw_rdata = 32'(s_r.rdata);
            default: s_nxt.sw_rdata = 32'h0000_0000;
         endcase
      end
      ////////////////////////////////////////////////////////////////////
      case (s_r.st)
         bfc_pkg::S_IDLE: begin
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.pins.oe_n = 1'b1;
            s_nxt.pins.we_n = 1'b1;
            s_nxt.pins.dq_oe_n = 1'b1;
            s_nxt.second = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.pins.write_protect = s_r.unlock && s_r.busy;
            case (s_r.op)
               bfc_pkg::OP_READ: begin
                  // leave status mode first
                  s_nxt.pins.dq_out = s_r.need_read_array ?
                     cmd(bfc_pkg::CMD_READ_ARRAY) : s_r.pins.dq_out;
                  s_nxt.st = s_r.need_read_array ?
                     bfc_pkg::S_WR : bfc_pkg::S_RD;
                  s_nxt.pins.addr = s_r.addr;
               end
               bfc_pkg::OP_PROG: begin
                  s_nxt.pins.dq_out = cmd(bfc_pkg::CMD_PROG_SETUP);
                  s_nxt.pins.addr = s_r.addr;
                  s_nxt.pins.write_protect = s_r.unlock;
                  s_nxt.busy = 1'b1;
                  s_nxt.st = bfc_pkg::S_WR;
               end
               bfc_pkg::OP_ERASE: begin
                  s_nxt.pins.dq_out = cmd(bfc_pkg::CMD_ERASE_SETUP);
                  s_nxt.pins.addr = s_r.addr;
                  s_nxt.pins.write_protect = s_r.unlock;
                  s_nxt.busy = 1'b1;
                  s_nxt.st = bfc_pkg::S_WR;
               end
               bfc_pkg::OP_IDENT: begin
                  s_nxt.pins.dq_out = cmd(bfc_pkg::CMD_IDENTIFY);
                  s_nxt.pins.addr = s_r.addr;
                  s_nxt.need_read_array = 1'b1;
                  s_nxt.st = bfc_pkg::S_WR;
               end
               bfc_pkg::OP_POWERDOWN: begin
                  s_nxt.pins.reset_powerdown_n = 1'b0;
                  s_nxt.need_read_array = 1'b0;
                  s_nxt.st = bfc_pkg::S_PD;
                  s_nxt.op = '0;
               end
               3'h0: ;
               default: s_nxt.op = '0;
            endcase
         end
         bfc_pkg::S_WR: begin
            // write cycle: data driven, we_n low for the pulse width
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.pins.dq_oe_n = 1'b0;
            s_nxt.cnt = s_r.cnt + 5'd1;
            if (s_r.cnt == bfc_pkg::WPULSE_CYC) begin
               s_nxt.pins.we_n = 1'b1;
               s_nxt.cnt = '0;
               s_nxt.st = bfc_pkg::S_WGAP;
            end
         end
         bfc_pkg::S_WGAP: begin
            // we_n rises with data still held, then release bus
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.pins.dq_oe_n = 1'b1;
            s_nxt.st = bfc_pkg::S_IDLE;
            if ((s_r.op == bfc_pkg::OP_PROG || s_r.op == bfc_pkg::OP_ERASE)
                && !s_r.second) begin
               s_nxt.second = 1'b1;
               s_nxt.pins.dq_out = (s_r.op == bfc_pkg::OP_PROG) ?
                  s_r.wdata : cmd(bfc_pkg::CMD_CONFIRM);
               s_nxt.st = bfc_pkg::S_WR;
            end else if (s_r.op == bfc_pkg::OP_PROG ||
                         s_r.op == bfc_pkg::OP_ERASE) begin
               s_nxt.need_read_array = 1'b1;
               s_nxt.st = bfc_pkg::S_POLL;
            end else if (s_r.op == bfc_pkg::OP_READ) begin
               s_nxt.need_read_array = 1'b0;
               s_nxt.st = bfc_pkg::S_RD;
            end else if (s_r.op == bfc_pkg::OP_IDENT) begin
               // code read at once; array mode still owed
               s_nxt.st = bfc_pkg::S_RD;
            end else begin
               s_nxt.op = '0;
            end
         end
         bfc_pkg::S_RD, bfc_pkg::S_POLL: begin
            // fresh ce/oe fall each sample refreshes status
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.oe_n = 1'b0;
            s_nxt.pins.dq_oe_n = 1'b1;
            s_nxt.cnt = s_r.cnt + 5'd1;
            if (s_r.cnt == bfc_pkg::ACCESS_CYC) begin
               s_nxt.pins.ce_n = 1'b1;
               s_nxt.pins.oe_n = 1'b1;
               s_nxt.cnt = '0;
               if (s_r.st == bfc_pkg::S_RD) begin
                  s_nxt.rdata = flash_dq_in;
                  s_nxt.op = '0;
                  s_nxt.st = bfc_pkg::S_IDLE;
               end else begin
                  s_nxt.st = bfc_pkg::S_DONE;
                  s_nxt.last_status = flash_dq_in[7:0];
               end
            end
         end
         bfc_pkg::S_DONE: begin
            // keep polling while the ready bit is low
            if (s_r.last_status[bfc_pkg::ST_READY]) begin
               s_nxt.busy = 1'b0;
               s_nxt.op = '0;
               s_nxt.st = bfc_pkg::S_IDLE;
               s_nxt.pins.write_protect = 1'b0;
            end else begin
               s_nxt.st = bfc_pkg::S_POLL;
            end
         end
         bfc_pkg::S_PD: begin
            if (s_r.op == bfc_pkg::OP_WAKE) begin
               s_nxt.pins.reset_powerdown_n = 1'b1;
               s_nxt.last_status = 8'h00;
               s_nxt.op = '0;
               s_nxt.st = bfc_pkg::S_IDLE;
            end
         end
         default: s_nxt.st = bfc_pkg::S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= '0;
         s_r.st <= bfc_pkg::S_IDLE;
         s_r.pins.ce_n <= 1'b1;
         s_r.pins.oe_n <= 1'b1;
         s_r.pins.we_n <= 1'b1;
         s_r.pins.dq_oe_n <= 1'b1;
         s_r.pins.reset_powerdown_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sw_rdata = s_r.sw_rdata;
   assign flash_ce_n = s_r.pins.ce_n;
   assign flash_oe_n = s_r.pins.oe_n;
   assign flash_we_n = s_r.pins.we_n;
   assign flash_reset_powerdown_n = s_r.pins.reset_powerdown_n;
   assign flash_write_protect = s_r.pins.write_protect;
   assign flash_addr = s_r.pins.addr[ADDR_W-1:0];
   assign flash_dq_out = s_r.pins.dq_out[DATA_W-1:0];
   assign flash_dq_oe_n = s_r.pins.dq_oe_n;

endmodule
`default_nettype wire

//--- logic/bfc_pkg.sv
// Purpose: constants and types for the flash host controller
// Assumes: 200 MHz system clock, flash pins driven synchronously
// Notes: command codes and status bit positions of the attached flash
package bfc_pkg;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_IDENTIFY = 8'h90;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   // status bits of the flash
   localparam int ST_READY = 7;
   localparam int ST_SUSP = 6;
   localparam int ST_ERASE_ERR = 5;
   localparam int ST_PROG_ERR = 4;
   localparam int ST_SUPPLY_ERR = 3;
   // software register map of the controller
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA = 4'h4;
   // ctrl op codes written to REG_CTRL[2:0]
   localparam logic [2:0] OP_READ = 3'h1;
   localparam logic [2:0] OP_PROG = 3'h2;
   localparam logic [2:0] OP_ERASE = 3'h3;
   localparam logic [2:0] OP_IDENT = 3'h4;
   localparam logic [2:0] OP_POWERDOWN = 3'h5;
   localparam logic [2:0] OP_WAKE = 3'h6;
   localparam int CTRL_BOOT_UNLOCK = 3;
   // timing: 90 ns access, 60 ns write pulse
   localparam int ACCESS_NS = 90;
   localparam int WPULSE_NS = 60;
   localparam int CLK_NS = 5;
   localparam logic [4:0] ACCESS_CYC = 5'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] WPULSE_CYC = 5'((WPULSE_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_WR = 7'b0000010,
      S_WGAP = 7'b0000100,
      S_RD = 7'b0001000,
      S_POLL = 7'b0010000,
      S_PD = 7'b0100000,
      S_DONE = 7'b1000000
   } bfc_state_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_powerdown_n;
      logic write_protect;
      logic [19:0] addr;
      logic [15:0] dq_out;
      logic dq_oe_n;
   } bfc_pins_t;
endpackage

//--- test/bfc_flash_model.sv
// Purpose: behavioural flash, 16 words in 4 blocks of 4
// Assumes: pins sampled on the bench clock
// Notes: undriven dq shows the inverse of the last read value
`timescale 1ns/1ps
`default_nettype none
module bfc_flash_model #(
   parameter int BUSY_CYC = 20,
   parameter logic [1:0] BOOT_BLK = 2'h0,
   parameter bit SUPPLY_OK = 1'b1,
   // identity values are arbitrary
   parameter logic [15:0] MFG_ID = 16'h00a5,
   parameter logic [15:0] DEV_ID = 16'h005a
) (
   input wire logic clock,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rp_n,
   input wire logic wp,
   input wire logic [19:0] addr,
   input wire logic [15:0] din,
   output logic [15:0] dout
);
   logic [15:0] mem [16];
   logic [15:0] rv, last;
   logic [7:0] st, st_lat, prev, err;
   logic [1:0] mode;
   logic we_d, oe_d, sel, ok;
   int busy;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0c00 + 16'(i);
      {st, st_lat, prev, mode, last} = '0;
      {we_d, oe_d} = 2'h3;
      busy = 0;
   end
   assign sel = rp_n && !ce_n && !oe_n && we_n;
   assign ok = SUPPLY_OK &&
      (addr[3:2] != BOOT_BLK || wp);
   assign err = {7'h00, !SUPPLY_OK} << 3;
   always_comb rv = mode == 2'h1 ? {8'h00, st_lat} :
      mode == 2'h2 ? (addr[0] ? DEV_ID : MFG_ID) :
      mem[addr[3:0]];
   assign dout = sel ? rv : ~last;
   always @(posedge clock) begin
      we_d <= we_n;
      oe_d <= oe_n;
      if (busy > 0) busy <= busy - 1;
      if (sel) last <= rv;
      if (!oe_n && oe_d) st_lat <= {busy == 0, st[6:0]};
      if (!rp_n) begin
         {st, prev, mode} <= '0;
      end else if (we_n && !we_d && !ce_n) begin
         prev <= din[7:0];
         if (busy > 0) begin
            if (din[7:0] == 8'h70) mode <= 2'h1;
         end else if (prev == 8'h40 || prev == 8'h10) begin
            mode <= 2'h1;
            prev <= 8'h00;
            if (ok) mem[addr[3:0]] <= din;
            if (ok) busy <= BUSY_CYC;
            else st <= st | err | 8'h10;
         end else if (prev == 8'h20 && din[7:0] == 8'hd0) begin
            mode <= 2'h1;
            prev <= 8'h00;
            for (int i = 0; i < 16; i++)
               if (ok && i[3:2] == addr[3:2])
                  mem[i] <= 16'hffff;
            if (ok) busy <= BUSY_CYC;
            else st <= st | err | 8'h20;
         end else begin
            case (din[7:0])
               8'hff: mode <= 2'h0;
               8'h90: mode <= 2'h2;
               8'h50: st <= 8'h00;
               default: mode <= 2'h1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- test/bfc_host_sva.sv
// Purpose: pin protocol checks for bfc_host
// Assumes: one clock, synchronous rst
// Notes: last_we_r holds the low byte of the previous flash write
`timescale 1ns/1ps
`default_nettype none
module bfc_host_sva #(
   parameter int DATA_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sw_read,
   input wire logic [31:0] sw_rdata,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_reset_powerdown_n,
   input wire logic flash_write_protect,
   input wire logic [DATA_W-1:0] flash_dq_out,
   input wire logic flash_dq_oe_n
);
   logic [7:0] last_we_r;
   logic prog_data;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   always_ff @(posedge clock) begin
      if (rst) last_we_r <= 8'h00;
      else if ($rose(flash_we_n)) last_we_r <= flash_dq_out[7:0];
   end
   // a write after program setup carries array data, not a command
   assign prog_data = last_we_r == bfc_pkg::CMD_PROG_SETUP;
   ////////////////////////////////////////////////////////////////////////
   a_write_no_read: assert property (
      !flash_we_n |-> flash_oe_n) else $error("we and oe low together");
   a_drive_no_read: assert property (
      !flash_dq_oe_n |-> flash_oe_n) else $error("dq driven in a read");
   a_confirm_order: assert property (
      $rose(flash_we_n) && !prog_data
      && flash_dq_out[7:0] == bfc_pkg::CMD_CONFIRM
      |-> last_we_r == bfc_pkg::CMD_ERASE_SETUP) else $error("bad confirm");
   a_data_after_setup: assert property (
      $rose(flash_we_n) && flash_dq_out[DATA_W-1:8] != '0 |-> prog_data)
      else $error("data write without setup");
   a_cmd_low_byte: assert property (
      $rose(flash_we_n) && !prog_data |-> flash_dq_out[DATA_W-1:8] == '0)
      else $error("command upper byte set");
   a_pd_quiet: assert property (
      !flash_reset_powerdown_n |-> flash_ce_n && flash_we_n)
      else $error("strobe in power-down");
   a_pulse_min: assert property (
      $fell(flash_we_n) |-> !flash_we_n [*8]) else $error("short write");
   a_unlock_held: assert property (
      !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_write_protect))
      else $error("unlock changed in cycle");
   a_reset_idle: assert property (disable iff (1'b0)
      rst |=> flash_ce_n && flash_we_n && flash_dq_oe_n
      && flash_reset_powerdown_n) else $error("pins busy after reset");
   a_rdata_once: assert property (
      !$past(sw_read) |-> sw_rdata == 32'h0000_0000)
      else $error("stray read data");
   c_confirm: cover property (
      $rose(flash_we_n) && flash_dq_out[7:0] == bfc_pkg::CMD_CONFIRM);
   c_powerdown: cover property ($fell(flash_reset_powerdown_n));
   c_unlocked: cover property (flash_write_protect && !flash_we_n);
endmodule
bind bfc_host bfc_host_sva #(.DATA_W(DATA_W)) bfc_host_sva_i (
   .clock(clock), .rst(rst), .sw_read(sw_read), .sw_rdata(sw_rdata),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_write_protect(flash_write_protect),
   .flash_reset_powerdown_n(flash_reset_powerdown_n),
   .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));
`default_nettype wire

//--- test/tb.sv
// Purpose: register level tests of bfc_host against the flash model
// Assumes: block 0 of the model is the boot block
// Notes: op leaves the final status word in d
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock, rst, sw_write, sw_read, ce_n, oe_n, we_n, rp_n, wp, dq_oe_n;
   logic [3:0] sw_addr;
   logic [31:0] sw_wdata, sw_rdata, d;
   logic [19:0] fa;
   logic [15:0] dq_out, mdq, bus;
   int errors, samples_checked;
   assign bus = dq_oe_n ? mdq : dq_out;
   bfc_host bfc_host_i (.clock(clock), .rst(rst), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
      .sw_rdata(sw_rdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_reset_powerdown_n(rp_n),
      .flash_write_protect(wp), .flash_addr(fa), .flash_dq_out(dq_out),
      .flash_dq_oe_n(dq_oe_n), .flash_dq_in(bus));
   bfc_flash_model bfc_flash_model_i (.clock(clock), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .wp(wp), .addr(fa),
      .din(bus), .dout(mdq));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      sw_addr <= a;
      sw_wdata <= v;
      sw_write <= 1'b1;
      @(posedge clock);
      sw_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clock);
      sw_read <= 1'b0;
      #1 d = sw_rdata;
   endtask
   task automatic op(input logic [2:0] o, input logic ul,
      input logic [19:0] a, input logic [15:0] w);
      wr(bfc_pkg::REG_ADDR, {12'h000, a});
      wr(bfc_pkg::REG_WDATA, {16'h0000, w});
      wr(bfc_pkg::REG_CTRL, {28'h000_0000, ul, o});
      // reads and identify raise no busy bit: let them finish first
      repeat (40) @(posedge clock);
      d = 32'h0000_0100;
      for (int i = 0; i < 400 && d[8] === 1'b1; i++) rd(bfc_pkg::REG_STATUS);
      chk({31'h0000_0000, d[8]}, 32'h0000_0000);
   endtask
   task automatic rdv(input logic [19:0] a, input logic [31:0] exp);
      op(bfc_pkg::OP_READ, 1'b0, a, 16'h0000);
      rd(bfc_pkg::REG_RDATA);
      chk(d, exp);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {sw_write, sw_read, sw_addr, sw_wdata, errors, samples_checked} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rd(bfc_pkg::REG_STATUS);
      chk(d, 32'h0000_0000);
      rd(4'hf);
      chk(d, 32'h0000_0000);
      rdv(20'h00005, 32'h0000_0c05);
      $display("test reset done");
      op(bfc_pkg::OP_PROG, 1'b0, 20'h00006, 16'ha5c3);
      chk(d, 32'h0000_0080);
      rdv(20'h00006, 32'h0000_a5c3);
      op(bfc_pkg::OP_ERASE, 1'b0, 20'h00005, 16'h0000);
      chk(d, 32'h0000_0080);
      rdv(20'h00006, 32'h0000_ffff);
      rdv(20'h00009, 32'h0000_0c09);
      $display("test program erase done");
      op(bfc_pkg::OP_PROG, 1'b0, 20'h00001, 16'h1357);
      chk(d, 32'h0000_0090);
      op(bfc_pkg::OP_ERASE, 1'b0, 20'h00002, 16'h0000);
      chk(d, 32'h0000_00b0);
      rdv(20'h00001, 32'h0000_0c01);
      op(bfc_pkg::OP_IDENT, 1'b0, 20'h00000, 16'h0000);
      chk(d & 32'h0000_0100, 32'h0000_0000);
      rd(bfc_pkg::REG_RDATA);
      chk(d, 32'h0000_00a5);
      op(bfc_pkg::OP_IDENT, 1'b0, 20'h00001, 16'h0000);
      rd(bfc_pkg::REG_RDATA);
      chk(d, 32'h0000_005a);
      op(bfc_pkg::OP_POWERDOWN, 1'b0, 20'h00000, 16'h0000);
      chk(d & 32'h0000_0200, 32'h0000_0200);
      op(bfc_pkg::OP_WAKE, 1'b0, 20'h00000, 16'h0000);
      chk(d & 32'h0000_0300, 32'h0000_0000);
      op(bfc_pkg::OP_PROG, 1'b1, 20'h00001, 16'h2468);
      chk(d, 32'h0000_0080);
      rdv(20'h00001, 32'h0000_2468);
      $display("test boot block done");
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
